//--- hdl/ppio_map.svh
// register offsets, field positions, reset values and pin numbers for
// the parallel port; included by the detector, the top file and the bench
`ifndef PPIO_MAP_SVH
`define PPIO_MAP_SVH

// register byte offsets on the local register port
`define PPIO_ADDR_DATA    8'h00
`define PPIO_ADDR_DIR     8'h04
`define PPIO_ADDR_ICFG_LO 8'h08
`define PPIO_ADDR_ICFG_HI 8'h0C

// reset values
`define PPIO_RST_WORD     32'h0000_0000
`define PPIO_RST_HALF     16'h0000
`define PPIO_RST_BYTE     8'h00

// direction register layout
`define PPIO_DIR_WMASK    32'h7FFF_FFFF
`define PPIO_DIR_GRP_HI   16
`define PPIO_DIR_GRP_LO   17
`define PPIO_PER_LSB      18
`define PPIO_PER_MSB      22
`define PPIO_PEN_LSB      23
`define PPIO_PEN_MSB      30

// pulse unit timing
`define PPIO_PRESC_W      4
`define PPIO_CNT_ONE      8'h01

// shared pin positions
`define PPIO_PIN_TX1      15
`define PPIO_PIN_RX1      14
`define PPIO_PIN_RTS1     13
`define PPIO_PIN_CTS1     12
`define PPIO_PIN_TX2      11
`define PPIO_PIN_RX2      10
`define PPIO_PIN_RTS2     9
`define PPIO_PIN_CTS2     8
`define PPIO_PIN_BOOT     4
`define PPIO_PIN_SCLK     3
`define PPIO_PIN_PW_MSB   1
`define PPIO_PIN_PW_LSB   0

`endif

//--- hdl/ppio_pkg.sv
// types shared by the parallel port and its interrupt detector
// assumes nothing of its surroundings
package ppio_pkg;

  // one interrupt configuration group, also a pulse duty value
  typedef struct packed {
    logic       en;
    logic       edge_sel;
    logic       pol;
    logic [4:0] sel;
  } ppio_icfg_s;

  // signals a serial unit hands to the shared pins
  typedef struct packed {
    logic tx_en;
    logic txd;
    logic flow_en;
    logic rts;
  } ppio_uart_s;

  // signals the shared pins hand back to a serial unit
  typedef struct packed {
    logic rxd;
    logic cts;
  } ppio_uart_rx_s;

  // state of one interrupt detector
  typedef struct packed {
    logic prev;
    logic irq;
  } ppio_irq_state_s;

endpackage

//--- hdl/ppio_irq_unit.sv
// one port interrupt detector: selects a synchronised port bit and
// qualifies it by level or edge; expects inputs already synchronised
`timescale 1ns/10ps
`default_nettype none
`include "ppio_map.svh"

module ppio_irq_unit
  import ppio_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire ppio_icfg_s  cfg_in,
  input  wire logic        suppress_in,
  input  wire logic [31:0] pins_in,
  output logic             irq_out
);

  ppio_irq_state_s q;
  ppio_irq_state_s next_q;
  logic            cur;

  // pick the selected port bit
  assign cur = pins_in[cfg_in.sel];

  // detector: previous sample kept even while masked
  always_comb begin
    next_q      = q;
    next_q.prev = cur;
    if (!cfg_in.en || suppress_in) begin
      next_q.irq = 1'b0;
    end else if (cfg_in.edge_sel) begin
      // one-cycle pulse per qualifying edge
      next_q.irq = cfg_in.pol ? (cur & ~q.prev) : (~cur & q.prev);
    end else begin
      next_q.irq = (cur == cfg_in.pol);
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign irq_out = q.irq;

endmodule
`default_nettype wire

//--- hdl/ppio_top.sv
// parallel port: 32 bits of general i/o, eight port interrupts and
// eight complementary pulse-width outputs on the dedicated pins
// assumes a single 20 MHz clock, synchronous active-low reset and a
// register master that never needs a wait state
//
// Notes on behaviour
// - low half on port pins, high half on data lines only if memory narrow
// - high half unusable whenever the sdram controller is on
// - low bits have own direction; high bits switch per byte
// - data read returns pin values; write drives bits set as outputs
// - low direction bit zero means input, one means output
// - direction bit 16 governs data 15:8, bit 17 governs data 7:0
// - reset clears every direction bit; all pins start as inputs
// - eight interrupt outputs for levels 4,5,6,7,10,12,13,15
// - config registers hold eight groups of enable, edge, polarity, selector
// - selector picks any one of the 32 port bits
// - polarity set means high or rising; clear means low or falling
// - edge bit set means edge triggered, else level sensitive
// - enable clear masks the interrupt; reset clears all enables
// - pulse enable n drives pins 2n and 2n+1
// - an enabled unit uses its config group as duty value
// - odd pin of each pair not taken by serial transmit or request is the inverse of the even pin
// - prescaled clock steps 8-bit counter with period four times field
// - interrupt suppressed while its pulse unit is enabled
// - period field resets to zero
// - pulse enables live in direction register bits 30 down to 23
// - serial transmit, request and receive signals share pins 8 to 15
// - pin 4 boot select, pin 3 serial clock, pins 1:0 boot width
// - external serial clock on pin 3 must stay below half clock rate
`timescale 1ns/10ps
`default_nettype none
`include "ppio_map.svh"

module ppio_top
  import ppio_pkg::*;
(
  input  wire logic          clk_sys_in,
  input  wire logic          resetn_in,
  // register port
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic [31:0]   reg_wdata_in,
  input  wire logic          reg_write_in,
  input  wire logic          reg_read_in,
  output logic      [31:0]   reg_rdata_out,
  // memory controller state
  input  wire logic          mem_all_narrow_in,
  input  wire logic          sdram_enabled_in,
  // dedicated port pins
  input  wire logic [15:0]   port_pins_in,
  output logic      [15:0]   port_pins_out,
  output logic      [15:0]   port_pins_oe_out,
  // upper half on the memory data lines
  input  wire logic [15:0]   mem_data_in,
  output logic      [15:0]   mem_data_out,
  output logic      [15:0]   mem_data_oe_out,
  // shared serial functions
  input  wire ppio_uart_s    serial_one_in,
  input  wire ppio_uart_s    serial_two_in,
  output ppio_uart_rx_s      serial_one_out,
  output ppio_uart_rx_s      serial_two_out,
  // boot straps and alternative serial clock
  output logic               boot_select_out,
  output logic               ext_serial_clk_out,
  output logic      [1:0]    boot_width_out,
  // port interrupts, bit 0..7 = levels 4,5,6,7,10,12,13,15
  output logic      [7:0]    irq_out
);

  // state of the port apart from the interrupt detectors
  typedef struct packed {
    logic [31:0]               data_out;
    logic [31:0]               dir;
    logic [31:0]               cfg_lo;
    logic [31:0]               cfg_hi;
    logic [31:0]               sync1;
    logic [31:0]               sync2;
    logic [`PPIO_PRESC_W-1:0]  presc;
    logic [7:0]                cnt;
    logic [31:0]               rdata;
    logic [15:0]               pin_o;
    logic [15:0]               pin_oe;
    logic [15:0]               mem_o;
    logic [15:0]               mem_oe;
    ppio_uart_rx_s             ser1;
    ppio_uart_rx_s             ser2;
    logic                      boot;
    logic                      sclk;
    logic [1:0]                width;
  } ppio_state_s;

  ppio_state_s    q;
  ppio_state_s    next_q;
  ppio_icfg_s [7:0] grp;
  logic [7:0]     pen;
  logic [4:0]     per;
  logic [7:0]     limit;
  logic           tick;
  logic           hi_ok;
  logic [7:0]     pwm_even;
  logic [15:0]    gpio_o;
  logic [15:0]    gpio_oe;

  // configuration groups, lowest byte of the low register first
  assign grp = {q.cfg_hi, q.cfg_lo};
  assign pen = q.dir[`PPIO_PEN_MSB:`PPIO_PEN_LSB];
  assign per = q.dir[`PPIO_PER_MSB:`PPIO_PER_LSB];

  // counter period is four times the field
  assign limit = {1'b0, per, 2'b00};
  assign tick  = &q.presc;

  // upper half usable only with narrow memory and sdram off
  assign hi_ok = mem_all_narrow_in & ~sdram_enabled_in;

  // interrupt detectors, one per level
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_irq
      ppio_irq_unit u_irq (
        .clk_sys_in  (clk_sys_in),
        .resetn_in   (resetn_in),
        .cfg_in      (grp[gi]),
        .suppress_in (pen[gi]),
        .pins_in     (q.sync2),
        .irq_out     (irq_out[gi])
      );
      // even pin high while the counter is below the duty value
      assign pwm_even[gi] = (q.cnt < grp[gi]);
    end
  endgenerate

  // pin output value and enable before the shared functions
  always_comb begin
    gpio_o  = q.data_out[15:0];
    gpio_oe = q.dir[15:0];
    for (int i = 0; i < 8; i++) begin
      if (pen[i]) begin
        gpio_o[2*i]     = pwm_even[i];
        gpio_o[2*i+1]   = ~pwm_even[i];
        gpio_oe[2*i]    = 1'b1;
        gpio_oe[2*i+1]  = 1'b1;
      end
    end
  end

  // next state
  always_comb begin
    next_q = q;

    // two-flop synchroniser for every port bit
    next_q.sync1 = {mem_data_in, port_pins_in};
    next_q.sync2 = q.sync1;

    // register writes
    if (reg_write_in) begin
      case (reg_addr_in)
        `PPIO_ADDR_DATA: begin
          next_q.data_out = reg_wdata_in;
        end
        `PPIO_ADDR_DIR: begin
          next_q.dir = reg_wdata_in & `PPIO_DIR_WMASK;
        end
        `PPIO_ADDR_ICFG_LO: begin
          next_q.cfg_lo = reg_wdata_in;
        end
        `PPIO_ADDR_ICFG_HI: begin
          next_q.cfg_hi = reg_wdata_in;
        end
        default: begin
          next_q.data_out = q.data_out;
        end
      endcase
    end

    // register reads, answered in the next cycle only
    next_q.rdata = `PPIO_RST_WORD;
    if (reg_read_in) begin
      case (reg_addr_in)
        `PPIO_ADDR_DATA: begin
          // upper half reads zero while it is not usable
          next_q.rdata = {hi_ok ? q.sync2[31:16] : `PPIO_RST_HALF,
                          q.sync2[15:0]};
        end
        `PPIO_ADDR_DIR: begin
          next_q.rdata = q.dir;
        end
        `PPIO_ADDR_ICFG_LO: begin
          next_q.rdata = q.cfg_lo;
        end
        `PPIO_ADDR_ICFG_HI: begin
          next_q.rdata = q.cfg_hi;
        end
        default: begin
          next_q.rdata = `PPIO_RST_WORD;
        end
      endcase
    end

    // prescaler and periodic counter
    next_q.presc = q.presc + 1'b1;
    if (per == 5'h00) begin
      next_q.cnt = `PPIO_RST_BYTE;
    end else if (tick) begin
      if (q.cnt >= limit - `PPIO_CNT_ONE) begin
        next_q.cnt = `PPIO_RST_BYTE;
      end else begin
        next_q.cnt = q.cnt + `PPIO_CNT_ONE;
      end
    end

    // dedicated pins with serial functions on top
    next_q.pin_o  = gpio_o;
    next_q.pin_oe = gpio_oe;
    if (serial_one_in.tx_en) begin
      next_q.pin_o[`PPIO_PIN_TX1]  = serial_one_in.txd;
      next_q.pin_oe[`PPIO_PIN_TX1] = 1'b1;
    end
    if (serial_one_in.flow_en) begin
      next_q.pin_o[`PPIO_PIN_RTS1]  = serial_one_in.rts;
      next_q.pin_oe[`PPIO_PIN_RTS1] = 1'b1;
    end
    if (serial_two_in.tx_en) begin
      next_q.pin_o[`PPIO_PIN_TX2]  = serial_two_in.txd;
      next_q.pin_oe[`PPIO_PIN_TX2] = 1'b1;
    end
    if (serial_two_in.flow_en) begin
      next_q.pin_o[`PPIO_PIN_RTS2]  = serial_two_in.rts;
      next_q.pin_oe[`PPIO_PIN_RTS2] = 1'b1;
    end

    // upper half on data lines, direction per byte group
    next_q.mem_o = q.data_out[31:16];
    next_q.mem_oe = {{8{q.dir[`PPIO_DIR_GRP_HI] & hi_ok}},
                     {8{q.dir[`PPIO_DIR_GRP_LO] & hi_ok}}};

    // serial inputs and straps from synchronised pins
    next_q.ser1.rxd = q.sync2[`PPIO_PIN_RX1];
    next_q.ser1.cts = q.sync2[`PPIO_PIN_CTS1];
    next_q.ser2.rxd = q.sync2[`PPIO_PIN_RX2];
    next_q.ser2.cts = q.sync2[`PPIO_PIN_CTS2];
    next_q.boot  = q.sync2[`PPIO_PIN_BOOT];
    // sampled clock is only faithful below half the system clock
    next_q.sclk  = q.sync2[`PPIO_PIN_SCLK];
    next_q.width = q.sync2[`PPIO_PIN_PW_MSB:`PPIO_PIN_PW_LSB];
  end

  // state register; reset clears directions, period and enables
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      q          <= '0;
      q.dir      <= `PPIO_RST_WORD;
      q.cfg_lo   <= `PPIO_RST_WORD;
      q.cfg_hi   <= `PPIO_RST_WORD;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_out      = q.rdata;
  assign port_pins_out      = q.pin_o;
  assign port_pins_oe_out   = q.pin_oe;
  assign mem_data_out       = q.mem_o;
  assign mem_data_oe_out    = q.mem_oe;
  assign serial_one_out     = q.ser1;
  assign serial_two_out     = q.ser2;
  assign boot_select_out    = q.boot;
  assign ext_serial_clk_out = q.sclk;
  assign boot_width_out     = q.width;

endmodule
`default_nettype wire

//--- testbench/ppio_pin_model.sv
// far-side devices on the 32 port lines
// assumes enables are high while the port drives a line
`timescale 1ns/10ps
`default_nettype none
module ppio_pin_model (
  input  wire logic        clk_sys_in,
  input  wire logic [31:0] drv_in,
  input  wire logic [31:0] oe_in,
  input  wire logic [31:0] ext_in,
  input  wire logic [31:0] ext_en_in,
  output logic      [31:0] pins_out
);
  logic [31:0] flt = 32'h5A5A_5A5A;
  // released lines show a pattern that flips every cycle
  always @(posedge clk_sys_in) begin
    flt <= ~flt;
  end
  // the port wins, then a device, else the floating pattern
  assign pins_out = oe_in & drv_in
                  | ~oe_in & (ext_en_in & ext_in | ~ext_en_in & flt);
endmodule
`default_nettype wire

//--- testbench/ppio_top_asserts.sv
// port-level assertions for the parallel port
// assumes ppio_pkg is compiled first; bound to ppio_top below
`timescale 1ns/10ps
`default_nettype none
module ppio_top_chk
  import ppio_pkg::*;
(
  input wire logic          clk_sys_in,
  input wire logic          resetn_in,
  input wire logic          reg_read_in,
  input wire logic [31:0]   reg_rdata_out,
  input wire logic          mem_all_narrow_in,
  input wire logic          sdram_enabled_in,
  input wire logic [15:0]   port_pins_in,
  input wire logic [15:0]   port_pins_out,
  input wire logic [15:0]   port_pins_oe_out,
  input wire logic [15:0]   mem_data_oe_out,
  input wire ppio_uart_s    serial_one_in,
  input wire ppio_uart_s    serial_two_in,
  input wire ppio_uart_rx_s serial_one_out,
  input wire logic          boot_select_out,
  input wire logic [7:0]    irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // steps that lead up to a checked output
  sequence upper_off;
    !mem_all_narrow_in || sdram_enabled_in;
  endsequence
  sequence rx_high;
    port_pins_in[14] [*5];
  endsequence
  sequence boot_low;
    (!port_pins_in[4]) [*5];
  endsequence
  reset_clear_a: assert property (disable iff (1'b0)
    !resetn_in |=> port_pins_oe_out == '0 && irq_out == '0)
    else $error("outputs not cleared by reset");
  upper_off_a: assert property (upper_off ##1 upper_off
    |-> mem_data_oe_out == '0) else $error("upper half driven");
  byte_group_a: assert property (
    mem_data_oe_out[15:8] inside {8'h00, 8'hFF} &&
    mem_data_oe_out[7:0] inside {8'h00, 8'hFF})
    else $error("upper enables split a byte");
  read_idle_a: assert property (!$past(reg_read_in)
    |-> reg_rdata_out == '0) else $error("read data outside slot");
  tx_pin_a: assert property ($past(serial_one_in.tx_en)
    |-> port_pins_oe_out[15] && port_pins_out[15] ==
    $past(serial_one_in.txd)) else $error("transmit pin wrong");
  rts_pin_a: assert property ($past(serial_two_in.flow_en)
    |-> port_pins_oe_out[9] && port_pins_out[9] ==
    $past(serial_two_in.rts)) else $error("request pin wrong");
  rx_pin_a: assert property (rx_high |-> serial_one_out.rxd)
    else $error("receive line not passed");
  boot_pin_a: assert property (boot_low |-> !boot_select_out)
    else $error("boot select not passed");
endmodule
bind ppio_top ppio_top_chk ppio_top_chk_inst (.clk_sys_in, .resetn_in,
  .reg_read_in, .reg_rdata_out, .mem_all_narrow_in, .sdram_enabled_in,
  .port_pins_in, .port_pins_out, .port_pins_oe_out, .mem_data_oe_out,
  .serial_one_in, .serial_two_in, .serial_one_out, .boot_select_out,
  .irq_out);
`default_nettype wire

//--- testbench/tb_parallel_io_port_pwm_irq.sv
// self-checking bench for the parallel port
// assumes design, pin model and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "ppio_map.svh"
module tb_parallel_io_port_pwm_irq
  import ppio_pkg::*;
;
  typedef struct {string n; logic [31:0] e, m;} ppio_rd_s;
  localparam logic [1:0] NO = 2'h0, WR = 2'h1, RD = 2'h2;
  logic clk, rstn, wr, rd, rd_d, nar, sdr, bsel, sclk;
  logic [1:0] bw;
  logic [7:0] adr, irq, ca;
  logic [15:0] po, pe, pi, mo, me, mi, h;
  logic [31:0] wd, rdat, d, v, ex, exen;
  ppio_uart_s s1, s2;
  ppio_uart_rx_s r1, r2;
  ppio_rd_s q[$];
  int n_mismatch, comparisons, seed, i, k, p, sh;
  ppio_top ppio_top_inst (.clk_sys_in(clk), .resetn_in(rstn),
    .reg_addr_in(adr), .reg_wdata_in(wd), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdat), .mem_all_narrow_in(nar),
    .sdram_enabled_in(sdr), .port_pins_in(pi), .port_pins_out(po),
    .port_pins_oe_out(pe), .mem_data_in(mi), .mem_data_out(mo),
    .mem_data_oe_out(me), .serial_one_in(s1), .serial_two_in(s2),
    .serial_one_out(r1), .serial_two_out(r2), .boot_select_out(bsel),
    .ext_serial_clk_out(sclk), .boot_width_out(bw), .irq_out(irq));
  ppio_pin_model ppio_pin_model_inst (.clk_sys_in(clk),
    .drv_in({mo, po}), .oe_in({me, pe}), .ext_in(ex),
    .ext_en_in(exen), .pins_out({mi, pi}));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // one bus cycle; a read also notes its expected data
  task automatic bus(input logic [1:0] op, input logic [7:0] a,
    input logic [31:0] v, m = 32'h0, input string n = "");
    @(posedge clk);
    wr <= op[0];
    rd <= op[1];
    adr <= a;
    wd <= v;
    if (op[1]) q.push_back('{n, v, m});
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    comparisons++;
    if (e !== s) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w8(input int c);
    bus(NO, 8'h00, 32'h0);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // read data watcher against the oldest note
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      chk(q[0].n, q[0].e & q[0].m, rdat & q[0].m);
      void'(q.pop_front());
    end
  end
  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    seed = 7319;
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; adr = 8'h00; wd = 32'h0;
    nar = 1'b1; sdr = 1'b0; s1 = '0; s2 = '0; ex = 32'h0; exen = '1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 5; i++) bus(RD, 8'(i * 4), 32'h0, '1, "reset");
    // direction groups, data drive, pin read-back
    for (i = 0; i < 4; i++) begin
      d = $random(seed) & 32'h8003_FFFF;
      v = $random(seed);
      bus(WR, `PPIO_ADDR_DIR, d);
      nar <= (i != 2);
      sdr <= (i == 3);
      exen <= {{16{i < 2}}, 16'hFFFF};
      ex <= $random(seed);
      bus(WR, `PPIO_ADDR_DATA, v);
      bus(RD, `PPIO_ADDR_DIR, d & 32'h0003_FFFF, '1, "dir");
      w8(4);
      h = (i < 2) ? {{8{d[16]}}, {8{d[17]}}} : 16'h0;
      chk("low oe", 32'(d[15:0]), 32'(pe));
      chk("high oe", 32'(h), 32'(me));
      chk("out", {v[31:16] & h, v[15:0] & d[15:0]}, {mo & h, po & d[15:0]});
      bus(RD, `PPIO_ADDR_DATA, {(i < 2) ? v[31:16] & h | ex[31:16] & ~h
        : 16'h0, v[15:0] & d[15:0] | ex[15:0] & ~d[15:0]}, '1, "data");
    end
    // all pins back to inputs so the selected pins follow the far side
    bus(WR, `PPIO_ADDR_DIR, 32'h0);
    // each interrupt: level, edge, mask
    for (i = 0; i < 8; i++) begin
      p = 5 + i;
      sh = (i % 4) * 8;
      ca = (i < 4) ? `PPIO_ADDR_ICFG_LO : `PPIO_ADDR_ICFG_HI;
      bus(WR, ca, 32'(8'hA0 | p) << sh);
      nar <= 1'b1; sdr <= 1'b0; exen <= '1; ex[p] <= 1'b0;
      w8(4);
      chk("irq idle", 32'h0, 32'(irq));
      bus(NO, 8'h00, 32'h0);
      ex[p] <= 1'b1;
      w8(3);
      chk("irq level", 32'(8'h01 << i), 32'(irq));
      bus(WR, ca, 32'(8'hC0 | p) << sh);
      bus(RD, ca, 32'(8'hC0 | p) << sh, '1, "cfg");
      w8(3);
      chk("irq edge idle", 32'h0, 32'(irq));
      bus(NO, 8'h00, 32'h0);
      ex[p] <= 1'b0;
      k = 0;
      repeat (8) begin
        @(negedge clk);
        if (irq[i] === 1'b1) k++;
      end
      chk("irq pulses", 32'h1, 32'(k));
      bus(WR, ca, 32'(p) << sh);
      w8(4);
      chk("irq masked", 32'h0, 32'(irq));
    end
    // pulse units 0 and 7: ratio, complement, enables
    bus(WR, `PPIO_ADDR_ICFG_LO, 32'h0000_0002);
    bus(WR, `PPIO_ADDR_DIR, 32'h4084_0000);
    w8(4);
    k = 0;
    repeat (64) begin
      @(negedge clk);
      if (po[0] === 1'b1) k++;
      chk("pulse pins", 32'h7B, 32'({pe[15:14], pe[1:0], po[15:14], po[1] ^ po[0]}));
    end
    chk("pulse high", 32'd32, 32'(k));
    bus(WR, `PPIO_ADDR_ICFG_LO, 32'h0000_00A5);
    ex[5] <= 1'b1;
    w8(6);
    chk("irq suppressed", 32'h0, 32'(irq));
    bus(WR, `PPIO_ADDR_DIR, 32'h0);
    w8(4);
    chk("irq freed", 32'h1, 32'(irq));
    // shared serial functions and straps under random traffic
    repeat (40) begin
      bus(NO, 8'h00, 32'h0);
      s1 <= 4'($random(seed));
      s2 <= 4'($random(seed));
      ex <= $random(seed);
    end
    bus(NO, 8'h00, 32'h0);
    s1 <= '0;
    s2 <= '0;
    w8(4);
    chk("straps", 32'({ex[14], ex[12], ex[10], ex[8], ex[4], ex[3], ex[1:0]}),
      32'({r1, r2, bsel, sclk, bw}));
    results();
  end
endmodule
`default_nettype wire
